// >>> hw/flash_host.v
// host controller that drives a 128K x 8 parallel flash through its pins
// assumes a single 50 MHz clock; flash data arrives asynchronously on I_DQ_IN pins
`timescale 1ns/1ns
`include "flash_host_defines.vh"
module flash_host #(
    parameter [31:0] PROG_TIMEOUT  = `PROG_MAX_CYC,
    parameter [39:0] ERASE_TIMEOUT = `ERASE_MAX_CYC,
    parameter        CE_CONTROLLED = 0,
    parameter [16:0] UNLOCK_A1     = 17'h05555,
    parameter [16:0] UNLOCK_A2     = 17'h02AAA,
    parameter [7:0]  UNLOCK_D1     = 8'hAA,
    parameter [7:0]  UNLOCK_D2     = 8'h55,
    parameter [7:0]  CMD_PROGRAM   = 8'hA0,
    parameter [7:0]  CMD_ERASE_1   = 8'h80,
    parameter [7:0]  CMD_ERASE_2   = 8'h10,
    parameter [7:0]  CMD_ID_ENTRY  = 8'h90,
    parameter [7:0]  CMD_ID_EXIT   = 8'hF0,
    parameter [7:0]  CMD_LOCKOUT   = 8'h40
) (
    input  wire        I_REF_CLK,
    input  wire        I_RST,
    input  wire        I_REQ,
    input  wire [2:0]  I_OP,
    input  wire [16:0] I_ADDR,
    input  wire [7:0]  I_WDATA,
    input  wire        I_BOOT_LOCKED,
    output wire        O_READY,
    output reg         O_DONE,
    output reg  [7:0]  O_RDATA,
    output reg         O_ERROR,
    output reg  [16:0] O_A,
    output reg  [7:0]  O_DQ_OUT,
    output wire        O_DQ_OE,
    input  wire [7:0]  I_DQ_IN,
    output wire        O_CE_N,
    output wire        O_OE_N,
    output wire        O_WE_N
);
    localparam S_IDLE  = 3'h0;
    localparam S_CMD   = 3'h1;
    localparam S_DATA  = 3'h2;
    localparam S_POLL  = 3'h3;
    localparam S_IDRD  = 3'h4;
    localparam S_IDEX  = 3'h5;
    localparam S_FIN   = 3'h6;

    reg [2:0]  state_r;
    reg [2:0]  op_r;
    reg [16:0] addr_r;
    reg [7:0]  wdata_r;
    reg [2:0]  step_r;
    reg        issued_r;
    reg        have_prev_r;
    reg        prev_bit_r;
    reg [39:0] wait_r;
    reg [7:0]  dq_s1_r;
    reg [7:0]  dq_s2_r;

    wire       cyc_done;
    wire [7:0] cyc_rdata;
    reg        cyc_start;
    reg        cyc_write;
    reg [16:0] seq_addr;
    reg [7:0]  seq_data;

    // command addresses are decoded on bits 14..0 only
    function [16:0] cmd_addr;
        input [16:0] a;
        begin
            cmd_addr = a & `CMD_ADDR_MASK;
        end
    endfunction

    // third byte of each three-write command
    function [7:0] third_cmd;
        input [2:0] op;
        begin
            case (op)
                `OP_PROGRAM: third_cmd = CMD_PROGRAM;
                `OP_ERASE:   third_cmd = CMD_ERASE_1;
                `OP_ID_READ: third_cmd = CMD_ID_ENTRY;
                `OP_LOCKOUT: third_cmd = CMD_LOCKOUT;
                default:     third_cmd = CMD_ID_EXIT;
            endcase
        end
    endfunction

    // erase repeats the unlock pair then issues the second erase byte
    always @* begin
        case (step_r)
            3'h0, 3'h3: begin
                seq_addr = cmd_addr(UNLOCK_A1);
                seq_data = UNLOCK_D1;
            end
            3'h1, 3'h4: begin
                seq_addr = cmd_addr(UNLOCK_A2);
                seq_data = UNLOCK_D2;
            end
            3'h2: begin
                seq_addr = cmd_addr(UNLOCK_A1);
                seq_data = (state_r == S_IDEX) ? CMD_ID_EXIT : third_cmd(op_r);
            end
            default: begin
                seq_addr = cmd_addr(UNLOCK_A1);
                seq_data = CMD_ERASE_2;
            end
        endcase
    end

    // flash data pins pass two flip-flops before any use
    always @(posedge I_REF_CLK) begin
        dq_s1_r <= I_DQ_IN;
        dq_s2_r <= dq_s1_r;
    end

    assign O_READY = (state_r == S_IDLE);

    flash_bus_cycle u_cycle (
        .I_REF_CLK  (I_REF_CLK),
        .I_RST      (I_RST),
        .i_start    (cyc_start),
        .i_write    (cyc_write),
        .i_ce_ctl   (CE_CONTROLLED != 0),
        .i_din_sync (dq_s2_r),
        .o_done     (cyc_done),
        .o_rdata    (cyc_rdata),
        .o_ce_n     (O_CE_N),
        .o_we_n     (O_WE_N),
        .o_oe_n     (O_OE_N),
        .o_dq_oe    (O_DQ_OE)
    );

    // start a bus cycle when one is not already under way
    always @* begin
        cyc_start = 1'b0;
        cyc_write = 1'b1;
        case (state_r)
            S_CMD, S_IDEX, S_DATA: cyc_start = !issued_r;
            S_POLL, S_IDRD: begin
                cyc_start = !issued_r;
                cyc_write = 1'b0;
            end
            default: cyc_start = 1'b0;
        endcase
    end

    // operation sequencer
    always @(posedge I_REF_CLK) begin
        if (I_RST) begin
            state_r     <= S_IDLE;
            op_r        <= `OP_READ;
            addr_r      <= 17'h00000;
            wdata_r     <= 8'h00;
            step_r      <= 3'h0;
            issued_r    <= 1'b0;
            have_prev_r <= 1'b0;
            prev_bit_r  <= 1'b0;
            wait_r      <= 40'h0000000000;
            O_DONE      <= 1'b0;
            O_RDATA     <= 8'h00;
            O_ERROR     <= 1'b0;
            O_A         <= 17'h00000;
            O_DQ_OUT    <= 8'h00;
        end else begin
            O_DONE <= 1'b0;
            if (cyc_start) begin
                issued_r <= 1'b1;
            end
            case (state_r)
                S_IDLE: begin
                    if (I_REQ) begin
                        op_r     <= I_OP;
                        addr_r   <= I_ADDR;
                        wdata_r  <= I_WDATA;
                        step_r   <= 3'h0;
                        issued_r <= 1'b0;
                        O_ERROR  <= 1'b0;
                        // locked boot block is refused by the device; skip it
                        if (I_OP == `OP_PROGRAM && I_BOOT_LOCKED
                                && I_ADDR <= `BOOT_LAST_ADDR) begin
                            O_ERROR <= 1'b1;
                            state_r <= S_FIN;
                        end else if (I_OP == `OP_READ) begin
                            O_A     <= I_ADDR;
                            state_r <= S_IDRD;
                        end else if (I_OP == `OP_RAW_WRITE) begin
                            O_A      <= I_ADDR;
                            O_DQ_OUT <= I_WDATA;
                            state_r  <= S_DATA;
                        end else begin
                            state_r <= S_CMD;
                        end
                    end
                end
                S_CMD, S_IDEX: begin
                    O_A      <= seq_addr;
                    O_DQ_OUT <= seq_data;
                    if (cyc_done) begin
                        issued_r <= 1'b0;
                        step_r   <= step_r + 3'h1;
                        if (state_r == S_IDEX && step_r == 3'h2) begin
                            state_r <= S_FIN; // back to normal mode
                        end else if (op_r == `OP_ERASE && step_r == 3'h5) begin
                            // erase ends on oe high, ce and we low writes
                            O_A     <= addr_r;
                            wait_r  <= 40'h0000000000;
                            have_prev_r <= 1'b0;
                            state_r <= S_POLL;
                        end else if (op_r != `OP_ERASE && step_r == 3'h2) begin
                            if (op_r == `OP_PROGRAM) begin
                                O_A      <= addr_r;
                                O_DQ_OUT <= wdata_r;
                                state_r  <= S_DATA;
                            end else if (op_r == `OP_ID_READ) begin
                                // upper lines low, low bit picks the code
                                O_A     <= {16'h0000, addr_r[0]};
                                state_r <= S_IDRD;
                            end else begin
                                wait_r      <= 40'h0000000000;
                                have_prev_r <= 1'b0;
                                state_r     <= S_POLL;
                            end
                        end
                    end
                end
                S_DATA: begin
                    if (cyc_done) begin
                        issued_r    <= 1'b0;
                        wait_r      <= 40'h0000000000;
                        have_prev_r <= 1'b0;
                        state_r     <= (op_r == `OP_RAW_WRITE) ? S_FIN : S_POLL;
                    end
                end
                S_POLL: begin
                    // address held constant over every polling read
                    wait_r <= wait_r + 40'h0000000001;
                    if (cyc_done) begin
                        issued_r    <= 1'b0;
                        have_prev_r <= 1'b1;
                        prev_bit_r  <= cyc_rdata[6];
                        // two reads in a row with equal bit 6 mean not busy
                        if (have_prev_r && prev_bit_r == cyc_rdata[6]) begin
                            O_RDATA <= cyc_rdata;
                            state_r <= S_FIN;
                        end else if (wait_r >= ((op_r == `OP_ERASE) ? ERASE_TIMEOUT
                                               : {8'h00, PROG_TIMEOUT})) begin
                            O_ERROR <= 1'b1; // operation overran its limit
                            state_r <= S_FIN;
                        end
                    end
                end
                S_IDRD: begin
                    if (cyc_done) begin
                        issued_r <= 1'b0;
                        O_RDATA  <= cyc_rdata;
                        step_r   <= 3'h0;
                        // leave identification mode at once
                        state_r  <= (op_r == `OP_ID_READ) ? S_IDEX : S_FIN;
                    end
                end
                S_FIN: begin
                    O_DONE  <= 1'b1;
                    state_r <= S_IDLE;
                end
                default: begin
                    state_r <= S_IDLE;
                end
            endcase
        end
    end
endmodule

// >>> hw/flash_host_defines.vh
// timing and address constants for the parallel flash host controller
// assumes a 50 MHz reference clock; included by the host modules
`ifndef FLASH_HOST_DEFINES_VH
`define FLASH_HOST_DEFINES_VH

`define CLK_PERIOD_NS      20
`define WRITE_PULSE_NS     90
`define WRITE_HIGH_NS      90
`define ADDR_HOLD_NS       50
`define READ_ACCESS_NS     120
`define STROBE_HIGH_NS     150
`define PROG_MAX_US        50
`define ERASE_MAX_S        10
// cycle counts: minimum times round up
`define WRITE_PULSE_CYC    ((`WRITE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WRITE_HIGH_CYC     ((`WRITE_HIGH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ADDR_HOLD_CYC      ((`ADDR_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_ACCESS_CYC    ((`READ_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STROBE_HIGH_CYC    ((`STROBE_HIGH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// poll budgets (in completed poll reads are not counted; cycles are)
`define PROG_MAX_CYC       (`PROG_MAX_US * 1000 / `CLK_PERIOD_NS)
`define ERASE_MAX_CYC      (`ERASE_MAX_S * 1000000 / `CLK_PERIOD_NS * 1000)
`define CMD_ADDR_MASK      17'h07FFF
`define BOOT_LAST_ADDR     17'h01FFF

// operation codes on i_op
`define OP_READ            3'h0
`define OP_PROGRAM         3'h1
`define OP_ERASE           3'h2
`define OP_ID_READ         3'h3
`define OP_LOCKOUT         3'h4
`define OP_RAW_WRITE       3'h5

// command sequence table: step count, address, data (parameters in the top)
`define SEQ_LEN            3
`endif

// >>> hw/flash_bus_cycle.v
// one strobe cycle on the flash pins: a timed write or a timed read
// assumes synchronised data input; the caller holds address and data stable
`timescale 1ns/1ns
`include "flash_host_defines.vh"
module flash_bus_cycle (
    input  wire        I_REF_CLK,
    input  wire        I_RST,
    input  wire        i_start,
    input  wire        i_write,
    input  wire        i_ce_ctl,
    input  wire [7:0]  i_din_sync,
    output wire        o_done,
    output reg  [7:0]  o_rdata,
    output reg         o_ce_n,
    output reg         o_we_n,
    output reg         o_oe_n,
    output reg         o_dq_oe
);
    localparam ST_IDLE = 2'h0;
    localparam ST_LOW  = 2'h1;
    localparam ST_HIGH = 2'h2;
    // read cycles wait for access plus the two-stage input sampler
    localparam integer LOW_W_I  = `WRITE_PULSE_CYC;
    localparam integer LOW_R_I  = `READ_ACCESS_CYC + 2;
    localparam integer HIGH_W_I = `WRITE_HIGH_CYC;
    localparam integer HIGH_R_I = `STROBE_HIGH_CYC;
    // counts are small; keep only the counter's width
    localparam [7:0]   LOW_W    = LOW_W_I[7:0];
    localparam [7:0]   LOW_R    = LOW_R_I[7:0];
    localparam [7:0]   HIGH_W   = HIGH_W_I[7:0];
    localparam [7:0]   HIGH_R   = HIGH_R_I[7:0];

    reg [1:0] state_r;
    reg [7:0] cnt_r;
    reg       wr_r;

    assign o_done = (state_r == ST_HIGH) && (cnt_r == 8'h00);

    // strobe sequencer: low phase then a recovery high phase
    always @(posedge I_REF_CLK) begin
        if (I_RST) begin
            state_r <= ST_IDLE;
            cnt_r   <= 8'h00;
            wr_r    <= 1'b0;
            o_ce_n  <= 1'b1;
            o_we_n  <= 1'b1;
            o_oe_n  <= 1'b1;
            o_dq_oe <= 1'b0;
            o_rdata <= 8'h00;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (i_start) begin
                        wr_r    <= i_write;
                        state_r <= ST_LOW;
                        cnt_r   <= (i_write ? LOW_W : LOW_R) - 8'h01;
                        o_dq_oe <= i_write;
                        if (i_write) begin
                            // write formed by ce or by we; oe stays high
                            o_ce_n <= 1'b0;
                            o_we_n <= 1'b0;
                        end else begin
                            o_ce_n <= 1'b0;
                            o_oe_n <= 1'b0;
                        end
                    end
                end
                ST_LOW: begin
                    if (cnt_r == 8'h00) begin
                        // both ce and oe rise, so each high pulse is timed
                        o_ce_n <= 1'b1;
                        // in ce mode we rises a cycle later, so ce closes the pulse
                        o_we_n <= !(wr_r && i_ce_ctl);
                        o_oe_n <= 1'b1;
                        if (!wr_r) begin
                            o_rdata <= i_din_sync;
                        end
                        state_r <= ST_HIGH;
                        cnt_r   <= (wr_r ? HIGH_W : HIGH_R) - 8'h01;
                    end else begin
                        cnt_r <= cnt_r - 8'h01;
                    end
                end
                ST_HIGH: begin
                    o_we_n <= 1'b1;
                    if (cnt_r == 8'h00) begin
                        o_dq_oe <= 1'b0;
                        state_r <= ST_IDLE;
                    end else begin
                        cnt_r <= cnt_r - 8'h01;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

// >>> test/flash_host_chk.sv
// pin-level assertions for the parallel flash host controller
// bound to every flash_host instance; sees only its ports
`timescale 1ns/1ns
module flash_host_chk (
    input logic        I_REF_CLK,
    input logic        I_RST,
    input logic        I_REQ,
    input logic [2:0]  I_OP,
    input logic [16:0] I_ADDR,
    input logic        I_BOOT_LOCKED,
    input logic        O_READY,
    input logic        O_DONE,
    input logic        O_ERROR,
    input logic [16:0] O_A,
    input logic        O_DQ_OE,
    input logic        O_CE_N,
    input logic        O_OE_N,
    input logic        O_WE_N
);
    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (I_RST);
    logic        oe_q;
    logic        seen;
    logic [16:0] rd_a;
    // remember the read address used within the running operation
    always @(posedge I_REF_CLK) begin
        oe_q <= O_OE_N;
        if (I_RST || O_DONE) begin
            seen <= 1'b0;
        end else if (oe_q && !O_OE_N) begin
            seen <= 1'b1;
            rd_a <= O_A;
        end
    end
    a_idle_strobes_high: assert property (O_READY |-> O_CE_N && O_OE_N && O_WE_N)
        else $error("strobe active while idle");
    a_done_one_cycle: assert property (O_DONE |=> !O_DONE)
        else $error("done longer than one cycle");
    a_take_goes_busy: assert property (I_REQ && O_READY |=> !O_READY)
        else $error("request not taken");
    a_write_oe_high: assert property (!O_WE_N |-> O_OE_N)
        else $error("output enable low during write");
    a_no_bus_fight: assert property (!O_OE_N |-> !O_DQ_OE)
        else $error("host drives data during read");
    a_write_low_width: assert property ($fell(O_WE_N) |-> !O_WE_N [*5])
        else $error("write pulse too short");
    a_write_high_width: assert property ($rose(O_WE_N) |-> O_WE_N [*5])
        else $error("write high time too short");
    a_poll_high_width: assert property ($rose(O_OE_N) |-> O_OE_N [*8])
        else $error("output enable high pulse too short");
    a_poll_addr_fixed: assert property ($fell(O_OE_N) && seen |-> O_A == rd_a)
        else $error("poll address moved");
    a_boot_refused: assert property (I_REQ && O_READY && I_OP == 3'h1 &&
        I_ADDR <= 17'h01FFF && I_BOOT_LOCKED |=> O_CE_N ##1 (O_DONE && O_ERROR && O_CE_N))
        else $error("locked boot program not refused");
    c_op_ok: cover property (O_DONE && !O_ERROR);
    c_op_err: cover property (O_DONE && O_ERROR);
    c_poll_again: cover property ($fell(O_OE_N) && seen);
endmodule

bind flash_host flash_host_chk u_flash_host_chk (
    .I_REF_CLK(I_REF_CLK), .I_RST(I_RST), .I_REQ(I_REQ), .I_OP(I_OP), .I_ADDR(I_ADDR),
    .I_BOOT_LOCKED(I_BOOT_LOCKED), .O_READY(O_READY), .O_DONE(O_DONE), .O_ERROR(O_ERROR),
    .O_A(O_A), .O_DQ_OE(O_DQ_OE), .O_CE_N(O_CE_N), .O_OE_N(O_OE_N), .O_WE_N(O_WE_N)
);

// >>> test/flash_model.sv
// behavioural flash device: command decoder, toggle status, id codes, boot lockout
// assumes the host drives the strobes; dq_w is the resolved data wire
`timescale 1ns/1ns
module flash_model #(
    parameter [7:0] MAKER_ID = 8'h5A, // arbitrary value
    parameter [7:0] PART_ID  = 8'hA5  // arbitrary value
) (
    input  wire [16:0] a,
    input  wire [7:0]  dq_w,
    input  wire        ce_n,
    input  wire        oe_n,
    input  wire        we_n,
    input  wire        stuck,
    output wire [7:0]  dq,
    output wire        drv
);
    logic [7:0] mem [0:131071];
    int         step = 0;
    int         busy = 0;
    logic       prog = 0;
    logic       arm = 0;
    logic       id_mode = 0;
    logic       locked = 0;
    logic       tog = 0;
    logic [7:0] last = 8'h00;
    wire        wr_act = !ce_n && !we_n;
    wire [7:0]  val = (id_mode && a[16:1] == 16'h0000) ? (a[0] ? PART_ID : MAKER_ID) :
                      (busy > 0) ? {1'b0, tog, 6'h00} : mem[a];
    // drive while read strobes are low; otherwise show a changing level
    assign drv = !ce_n && !oe_n;
    assign dq  = drv ? val : ~last;
    initial foreach (mem[i]) mem[i] = 8'hFF;
    // a byte is latched where the pulse ends, whichever strobe closes it
    always @(negedge wr_act) begin
        if (prog) begin
            prog = 0;
            if (!(locked && a <= 17'h01FFF)) begin
                mem[a] = mem[a] & dq_w;
                busy = 4;
            end
        end else if (step == 0) begin
            step = (a[14:0] == 15'h5555 && dq_w == 8'hAA) ? 1 : 0;
        end else if (step == 1) begin
            step = (a[14:0] == 15'h2AAA && dq_w == 8'h55) ? 2 : 0;
        end else begin
            step = 0;
            if (a[14:0] == 15'h5555) begin
                case (dq_w)
                    8'hA0: prog = 1;
                    8'h80: arm = 1;
                    8'h10: if (arm) begin
                        foreach (mem[i]) mem[i] = 8'hFF;
                        busy = 6;
                    end
                    8'h90: id_mode = 1;
                    8'hF0: id_mode = 0;
                    8'h40: locked = 1;
                    default: ;
                endcase
            end
            if (dq_w != 8'h80) arm = 0;
        end
    end
    // each completed read while busy and not in id mode flips the status bit
    always @(negedge drv) begin
        last = val;
        if (busy > 0 && !id_mode) begin
            tog = ~tog;
            if (!stuck) busy = busy - 1;
        end
    end
endmodule

// >>> test/flash_host_bench.sv
// self-checking bench for the flash host against a behavioural device model
// assumes the host tops out at one operation at a time, 50 MHz clock
`timescale 1ns/1ns
module flash_host_bench;
    localparam [7:0] MAKER = 8'h5A; // arbitrary value
    localparam [7:0] PART  = 8'hA5; // arbitrary value
`define CHECK(got, exp, msg) begin tests_run++; if ((got) !== (exp)) begin num_errors++; \
    $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp); end end
    logic        I_REF_CLK = 0, I_RST = 1, I_REQ = 0, I_BOOT_LOCKED = 0, stuck = 0;
    logic [2:0]  I_OP = 3'h0;
    logic [16:0] I_ADDR = 17'h00000, ad;
    logic [7:0]  I_WDATA = 8'h00, dt, dt2;
    wire         O_READY, O_DONE, O_ERROR, O_DQ_OE, O_CE_N, O_OE_N, O_WE_N, drv;
    wire [7:0]   O_RDATA, O_DQ_OUT, mdq, dq_w;
    wire [16:0]  O_A;
    int          num_errors = 0, tests_run = 0, cyc = 0;
    // resolve the shared data wire from both parties
    assign dq_w = drv ? mdq : (O_DQ_OE ? O_DQ_OUT : mdq);
    flash_host #(.PROG_TIMEOUT(32'd2000), .ERASE_TIMEOUT(40'd4000)) u_flash_host (
        .I_REF_CLK(I_REF_CLK), .I_RST(I_RST), .I_REQ(I_REQ), .I_OP(I_OP), .I_ADDR(I_ADDR),
        .I_WDATA(I_WDATA), .I_BOOT_LOCKED(I_BOOT_LOCKED), .O_READY(O_READY), .O_DONE(O_DONE),
        .O_RDATA(O_RDATA), .O_ERROR(O_ERROR), .O_A(O_A), .O_DQ_OUT(O_DQ_OUT),
        .O_DQ_OE(O_DQ_OE), .I_DQ_IN(dq_w), .O_CE_N(O_CE_N), .O_OE_N(O_OE_N), .O_WE_N(O_WE_N));
    flash_model #(.MAKER_ID(MAKER), .PART_ID(PART)) u_flash_model (
        .a(O_A), .dq_w(dq_w), .ce_n(O_CE_N), .oe_n(O_OE_N), .we_n(O_WE_N), .stuck(stuck),
        .dq(mdq), .drv(drv));
    // second host forms every write with chip enable; it runs in step with the first
    wire         rdy2, done2, err2, dqoe2, ce2_n, oe2_n, we2_n, drv2;
    wire [7:0]   rdata2, dout2, mdq2, dq2_w;
    wire [16:0]  a2;
    assign dq2_w = drv2 ? mdq2 : (dqoe2 ? dout2 : mdq2);
    flash_host #(.PROG_TIMEOUT(32'd2000), .ERASE_TIMEOUT(40'd4000), .CE_CONTROLLED(1))
        u_flash_host_ce (
        .I_REF_CLK(I_REF_CLK), .I_RST(I_RST), .I_REQ(I_REQ), .I_OP(I_OP), .I_ADDR(I_ADDR),
        .I_WDATA(I_WDATA), .I_BOOT_LOCKED(I_BOOT_LOCKED), .O_READY(rdy2), .O_DONE(done2),
        .O_RDATA(rdata2), .O_ERROR(err2), .O_A(a2), .O_DQ_OUT(dout2),
        .O_DQ_OE(dqoe2), .I_DQ_IN(dq2_w), .O_CE_N(ce2_n), .O_OE_N(oe2_n), .O_WE_N(we2_n));
    flash_model #(.MAKER_ID(MAKER), .PART_ID(PART)) u_flash_model_ce (
        .a(a2), .dq_w(dq2_w), .ce_n(ce2_n), .oe_n(oe2_n), .we_n(we2_n), .stuck(stuck),
        .dq(mdq2), .drv(drv2));
    initial forever #10 I_REF_CLK = ~I_REF_CLK;
    // cycle ceiling against hangs
    always @(posedge I_REF_CLK) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            num_errors++;
            finish_test();
        end
    end
    function automatic logic [7:0] exp_prog(input logic [7:0] old, input logic [7:0] nw);
        return old & nw;
    endfunction
    function automatic logic [7:0] exp_id(input logic sel);
        return sel ? PART : MAKER;
    endfunction
    // one request, raised for one cycle once ready, then wait for completion
    task automatic op(input logic [2:0] o, input logic [16:0] adr, input logic [7:0] wd);
        int n;
        n = 0;
        while (O_READY !== 1'b1 && n < 100) begin @(negedge I_REF_CLK); n++; end
        I_OP = o; I_ADDR = adr; I_WDATA = wd; I_REQ = 1'b1;
        @(negedge I_REF_CLK);
        I_REQ = 1'b0;
        n = 0;
        while (O_DONE !== 1'b1 && n < 5000) begin @(negedge I_REF_CLK); n++; end
        `CHECK({O_DONE, done2}, 2'b11, "no done")
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        void'($urandom(32'h8b1c));
        repeat (2) @(negedge I_REF_CLK);
        I_RST = 1'b0;
        `CHECK({O_READY, O_CE_N, O_OE_N, O_WE_N, O_DQ_OE, rdy2, ce2_n, we2_n}, 8'hF7, "reset state")
        op(3'h2, 17'h0ABCD, 8'h00);
        `CHECK(O_ERROR, 1'b0, "erase")
        $display("test erase done");
        for (int i = 0; i < 5; i++) begin
            ad = (i == 0) ? 17'h02000 : (i == 1) ? 17'h1FFFF : 17'h02000 + 17'($urandom % 32'h1E000);
            dt = 8'($urandom);
            dt2 = 8'($urandom);
            op(3'h1, ad, dt);
            `CHECK({O_ERROR, err2}, 2'b00, "program")
            op(3'h0, ad, 8'h00);
            `CHECK(O_RDATA, exp_prog(8'hFF, dt), "readback")
            `CHECK(rdata2, exp_prog(8'hFF, dt), "readback ce write")
            op(3'h1, ad, dt2);
            op(3'h0, ad, 8'h00);
            `CHECK(O_RDATA, exp_prog(dt, dt2), "reprogram")
        end
        $display("test program done");
        for (int k = 0; k < 2; k++) begin
            op(3'h3, 17'(k), 8'h00);
            `CHECK(O_RDATA, exp_id(k[0]), "id code")
        end
        op(3'h0, ad, 8'h00);
        `CHECK(O_RDATA, exp_prog(dt, dt2), "read after id")
        $display("test id done");
        // command sequence issued by hand through raw writes, then status reads
        op(3'h5, 17'h05555, 8'hAA);
        op(3'h5, 17'h02AAA, 8'h55);
        op(3'h5, 17'h05555, 8'hA0);
        op(3'h5, 17'h04000, dt);
        op(3'h0, 17'h04000, 8'h00);
        dt2 = O_RDATA;
        op(3'h0, 17'h04000, 8'h00);
        `CHECK(O_RDATA[6], ~dt2[6], "status bit did not toggle")
        repeat (3) op(3'h0, 17'h04000, 8'h00);
        `CHECK({O_RDATA, rdata2}, {2{exp_prog(8'hFF, dt)}}, "raw write program")
        $display("test raw write done");
        op(3'h4, 17'h00000, 8'h00);
        I_BOOT_LOCKED = 1'b1;
        op(3'h1, 17'h01FFF, 8'h00);
        `CHECK({O_ERROR, err2}, 2'b11, "locked boot program")
        op(3'h1, 17'h02000, 8'h00);
        `CHECK(O_ERROR, 1'b0, "program above boot block")
        I_BOOT_LOCKED = 1'b0;
        op(3'h1, 17'h00000, 8'h00);
        op(3'h0, 17'h00000, 8'h00);
        `CHECK(O_RDATA, 8'hFF, "device keeps boot block")
        $display("test lockout done");
        stuck = 1'b1;
        op(3'h1, 17'h03000, 8'h0F);
        `CHECK({O_ERROR, err2}, 2'b11, "poll limit")
        $display("test timeout done");
        finish_test();
    end
endmodule
